/* File: design/xlsd_core.sv */
/*
 * Transmit buffer, idle generation, per-lane byte sync and lane deskew.
 * Assumes the transceivers do 8B/10B coding, comma alignment and
 * elastic buffering, and share clk_i with this logic.
 */
// Contract
// RQ1 - Lane data leaves toward the transceivers, which 8B/10B code each lane.
// RQ2 - Idle columns are replaced by comma and align code groups on transmit.
// RQ3 - Each received lane has its own sync machine finding its byte boundary.
// RQ4 - One deskew machine lines up the four received lanes.
// RQ5 - Client transmit data reaches the transceiver output three cycles later.
// RQ6 - An upper transceiver byte leaves on the lower client column after four cycles.
// RQ7 - A lower transceiver byte leaves on the upper client column after three cycles.
// RQ8 - The wrapper option adds one transmit register stage.
// RQ9 - The wrapper option adds one receive register stage.
// RQ10 - Double rate operation only doubles clocks; the logic is unchanged.
// RQ11 - The client gives one control bit per transmit byte.
// RQ12 - The core gives one control bit per received byte.
// RQ13 - Deskew starts only once every lane reports sync.
`timescale 1ns/100ps

module xlsd_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } xlsd_fifo_st_t;

    xlsd_fifo_st_t q_r;
    xlsd_fifo_st_t q_nxt;
    logic push;
    logic pop;

    assign in_ready_o = q_r.cnt != DEPTH[AW:0];
    assign out_valid_o = q_r.cnt != '0;
    assign out_data_o = q_r.mem[q_r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.mem[q_r.wp] = in_data_i;
            q_nxt.wp = (q_r.wp == AW'(DEPTH - 1)) ? '0 : q_r.wp + 1'b1;
        end
        if (pop) begin
            q_nxt.rp = (q_r.rp == AW'(DEPTH - 1)) ? '0 : q_r.rp + 1'b1;
        end
        if (push && !pop) begin
            q_nxt.cnt = q_r.cnt + 1'b1;
        end else if (pop && !push) begin
            q_nxt.cnt = q_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule : xlsd_fifo

module xlsd_core #(
    parameter bit EXTRA_TX_PIPE = 1'b0,
    parameter bit EXTRA_RX_PIPE = 1'b0,
    parameter int FIFO_DEPTH = xlsd_pkg::FIFO_DEPTH
) (
    // clock and reset; RQ10 rate agnostic, clk_i may run at double rate
    input wire logic clk_i,
    input wire logic rst_i,
    // client transmit
    input wire xlsd_pkg::xlsd_xgmii_t xgmii_tx_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // transceiver transmit
    input wire logic mgt_tx_ready_i,
    output xlsd_pkg::xlsd_xgmii_t mgt_tx_o,
    // transceiver receive
    input wire xlsd_pkg::xlsd_mgt_rx_t mgt_rx_i,
    // client receive
    output xlsd_pkg::xlsd_xgmii_t xgmii_rx_o,
    // status and transceiver control
    output logic [3:0] mgt_align_en_o,
    output logic [3:0] lane_sync_o,
    output logic align_o
);
    localparam int L = xlsd_pkg::LANES;
    localparam int S = xlsd_pkg::SKEW_MAX;

    typedef struct packed {
        xlsd_pkg::xlsd_xgmii_t tx_a;
        xlsd_pkg::xlsd_xgmii_t tx_o;
        xlsd_pkg::xlsd_xgmii_t tx_x;
        logic [3:0] acnt;
        xlsd_pkg::xlsd_mgt_rx_t r1;
        xlsd_pkg::xlsd_mgt_rx_t r1p;
        xlsd_pkg::xlsd_lane_t [L-1:0][S:0] hist;
        xlsd_pkg::xlsd_sync_t [L-1:0] sync;
        logic [L-1:0][2:0] ccnt;
        logic [L-1:0][2:0] ecnt;
        xlsd_pkg::xlsd_dsk_t ds;
        logic [L-1:0] seen;
        logic [L-1:0][1:0] age;
        logic [L-1:0][1:0] dly;
        xlsd_pkg::xlsd_xgmii_t rx_o;
        xlsd_pkg::xlsd_xgmii_t rx_x;
    } xlsd_st_t;

    xlsd_st_t q_r;
    xlsd_st_t q_nxt;
    logic [71:0] fifo_q;
    logic fifo_v;

    // buffer stage; a stalled line keeps the client waiting via tx_ready_o
    xlsd_fifo #(.WIDTH(72), .DEPTH(FIFO_DEPTH)) u_txbuf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(xgmii_tx_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .out_data_o(fifo_q),
        .out_valid_o(fifo_v),
        .out_ready_i(mgt_tx_ready_i)
    );

    // client column layout to lane layout, idle columns recoded
    function automatic xlsd_pkg::xlsd_xgmii_t tx_map(
        input xlsd_pkg::xlsd_xgmii_t w,
        input logic align
    );
        xlsd_pkg::xlsd_xgmii_t r;
        logic idle;
        r = '0;
        for (int c = 0; c < 2; c++) begin
            idle = w.c[4*c +: 4] == 4'hF;
            for (int l = 0; l < L; l++) begin
                idle = idle && (w.d[8*(4*c+l) +: 8] == xlsd_pkg::K_IDLE);
            end
            for (int l = 0; l < L; l++) begin
                r.c[2*l+c] = w.c[4*c+l];
                r.d[8*(2*l+c) +: 8] = w.d[8*(4*c+l) +: 8];
                // RQ2 idle recoding
                if (idle) begin
                    r.d[8*(2*l+c) +: 8] = (align && c == 0) ?
                        xlsd_pkg::K_ALIGN : xlsd_pkg::K_COMMA;
                end
            end
        end
        return r;
    endfunction : tx_map

    // received byte to client byte; sync code groups read back as idle
    function automatic logic [8:0] rx_map(
        input logic [7:0] d,
        input logic k,
        input logic ok
    );
        logic [8:0] r;
        r = {k, d};
        if (!ok) begin
            r = {1'b1, xlsd_pkg::K_ERROR};
        end else if (k && (d == xlsd_pkg::K_COMMA ||
                           d == xlsd_pkg::K_ALIGN ||
                           d == xlsd_pkg::K_SKIP)) begin
            r = {1'b1, xlsd_pkg::K_IDLE};
        end
        return r;
    endfunction : rx_map

    function automatic logic has_align(input xlsd_pkg::xlsd_lane_t w);
        return (w.k[0] && w.ok[0] && w.d[7:0] == xlsd_pkg::K_ALIGN) ||
               (w.k[1] && w.ok[1] && w.d[15:8] == xlsd_pkg::K_ALIGN);
    endfunction : has_align

    always_comb begin
        xlsd_pkg::xlsd_xgmii_t word;
        xlsd_pkg::xlsd_lane_t lw;
        logic [8:0] b;
        logic comma;
        logic bad;
        logic all_seen;
        logic any_a;
        logic mis;
        q_nxt = q_r;
        word = xlsd_pkg::IDLE_WORD;
        lw = '0;
        b = '0;
        comma = 1'b0;
        bad = 1'b0;
        all_seen = 1'b1;
        any_a = 1'b0;
        mis = 1'b0;

        // RQ5 three stage path: buffer, idle select register, recode and output register
        if (fifo_v && mgt_tx_ready_i) begin
            word = fifo_q;
        end
        q_nxt.tx_a = word;
        // RQ1 lane ordered words toward the coders
        q_nxt.tx_o = tx_map(q_r.tx_a, q_r.acnt == '0);
        q_nxt.tx_x = q_r.tx_o;
        q_nxt.acnt = (q_r.acnt == xlsd_pkg::ALIGN_LAST) ? '0 : q_r.acnt + 1'b1;

        // RQ6 upper byte taken from the older word into column 0
        q_nxt.r1 = mgt_rx_i;
        q_nxt.r1p = q_r.r1;
        for (int l = 0; l < L; l++) begin
            // RQ7 lower byte of the newer word into column 1
            lw.d = {q_r.r1.data[16*l +: 8], q_r.r1p.data[16*l+8 +: 8]};
            lw.k = {q_r.r1.isk[2*l], q_r.r1p.isk[2*l+1]};
            lw.ok = {q_r.r1.valid[2*l], q_r.r1p.valid[2*l+1]};
            q_nxt.hist[l][0] = lw;
            for (int i = 1; i <= S; i++) begin
                q_nxt.hist[l][i] = q_r.hist[l][i-1];
            end

            // RQ3 per-lane boundary lock
            comma = |(q_r.r1.comma[2*l +: 2] & q_r.r1.valid[2*l +: 2]);
            bad = ~&q_r.r1.valid[2*l +: 2];
            case (q_r.sync[l])
                xlsd_pkg::SY_LOSS: begin
                    q_nxt.ecnt[l] = '0;
                    q_nxt.ccnt[l] = 3'h1;
                    if (comma && !bad) begin
                        q_nxt.sync[l] = xlsd_pkg::SY_COMMA;
                    end
                end
                xlsd_pkg::SY_COMMA: begin
                    if (bad) begin
                        q_nxt.sync[l] = xlsd_pkg::SY_LOSS;
                    end else if (comma) begin
                        q_nxt.ccnt[l] = q_r.ccnt[l] + 1'b1;
                        if (q_r.ccnt[l] + 3'h1 == xlsd_pkg::SYNC_COMMAS) begin
                            q_nxt.sync[l] = xlsd_pkg::SY_LOCK;
                        end
                    end
                end
                xlsd_pkg::SY_LOCK: begin
                    // isolated errors are forgiven by later clean words
                    if (bad) begin
                        q_nxt.ecnt[l] = q_r.ecnt[l] + 1'b1;
                        if (q_r.ecnt[l] + 3'h1 == xlsd_pkg::SYNC_ERRS) begin
                            q_nxt.sync[l] = xlsd_pkg::SY_LOSS;
                        end
                    end else if (q_r.ecnt[l] != '0) begin
                        q_nxt.ecnt[l] = q_r.ecnt[l] - 1'b1;
                    end
                end
                default: q_nxt.sync[l] = xlsd_pkg::SY_LOSS;
            endcase
        end

        // RQ4 single deskew machine
        case (q_r.ds)
            xlsd_pkg::DS_WAIT: begin
                q_nxt.seen = '0;
                q_nxt.age = '0;
                // RQ13 wait for every lane
                if (q_r.sync == {L{xlsd_pkg::SY_LOCK}}) begin
                    q_nxt.ds = xlsd_pkg::DS_ACQ;
                end
            end
            xlsd_pkg::DS_ACQ: begin
                for (int l = 0; l < L; l++) begin
                    if (q_r.seen[l]) begin
                        q_nxt.age[l] = q_r.age[l] + 1'b1;
                        mis = mis || q_r.age[l] == xlsd_pkg::SKEW_LIMIT;
                    end else if (has_align(q_r.hist[l][0])) begin
                        q_nxt.seen[l] = 1'b1;
                        q_nxt.age[l] = '0;
                    end
                    all_seen = all_seen && q_nxt.seen[l];
                end
                // RQ13 a lane dropping lock ends the search
                if (q_r.sync != {L{xlsd_pkg::SY_LOCK}}) begin
                    q_nxt.ds = xlsd_pkg::DS_WAIT;
                // skew beyond the delay line: start the search again
                end else if (mis) begin
                    q_nxt.seen = '0;
                end else if (all_seen) begin
                    q_nxt.dly = q_nxt.age;
                    q_nxt.ds = xlsd_pkg::DS_ALIGNED;
                end
            end
            xlsd_pkg::DS_ALIGNED: begin
                for (int l = 0; l < L; l++) begin
                    any_a = any_a || has_align(q_r.hist[l][q_r.dly[l]]);
                    all_seen = all_seen && has_align(q_r.hist[l][q_r.dly[l]]);
                end
                if (q_r.sync != {L{xlsd_pkg::SY_LOCK}}) begin
                    q_nxt.ds = xlsd_pkg::DS_WAIT;
                end else if (any_a && !all_seen) begin
                    q_nxt.seen = '0;
                    q_nxt.ds = xlsd_pkg::DS_ACQ;
                end
            end
            default: q_nxt.ds = xlsd_pkg::DS_WAIT;
        endcase

        // RQ12 one control bit per client byte
        for (int l = 0; l < L; l++) begin
            lw = q_r.hist[l][q_r.dly[l]];
            for (int c = 0; c < 2; c++) begin
                b = rx_map(lw.d[8*c +: 8], lw.k[c], lw.ok[c]);
                if (q_r.ds != xlsd_pkg::DS_ALIGNED) begin
                    b = {1'b1, xlsd_pkg::K_ERROR};
                end
                q_nxt.rx_o.c[4*c+l] = b[8];
                q_nxt.rx_o.d[8*(4*c+l) +: 8] = b[7:0];
            end
        end
        q_nxt.rx_x = q_r.rx_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
            q_r.sync <= {L{xlsd_pkg::SY_LOSS}};
            q_r.ds <= xlsd_pkg::DS_WAIT;
            q_r.tx_a <= xlsd_pkg::IDLE_WORD;
        end else begin
            q_r <= q_nxt;
        end
    end

    // RQ8 optional extra transmit stage
    assign mgt_tx_o = EXTRA_TX_PIPE ? q_r.tx_x : q_r.tx_o;
    // RQ9 optional extra receive stage
    assign xgmii_rx_o = EXTRA_RX_PIPE ? q_r.rx_x : q_r.rx_o;
    assign align_o = q_r.ds == xlsd_pkg::DS_ALIGNED;
    for (genvar l = 0; l < L; l++) begin : g_lane
        assign lane_sync_o[l] = q_r.sync[l] == xlsd_pkg::SY_LOCK;
        assign mgt_align_en_o[l] = q_r.sync[l] != xlsd_pkg::SY_LOCK;
    end
endmodule : xlsd_core

/* File: design/xlsd_pkg.sv */
/*
 * Shared constants and carrier types for the four-lane sync/deskew core.
 * Assumes an 8B/10B capable transceiver per lane with a two-byte
 * interface, running on the same user clock as the core.
 */
package xlsd_pkg;
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int TX_LATENCY = 3;
    localparam int SKEW_MAX = 3;

    // code group values
    localparam logic [7:0] K_IDLE = 8'h07;
    localparam logic [7:0] K_COMMA = 8'hBC;
    localparam logic [7:0] K_ALIGN = 8'h7C;
    localparam logic [7:0] K_SKIP = 8'h1C;
    localparam logic [7:0] K_ERROR = 8'hFE;

    // acquisition and loss thresholds, align column period
    localparam logic [2:0] SYNC_COMMAS = 3'h4;
    localparam logic [2:0] SYNC_ERRS = 3'h4;
    localparam logic [3:0] ALIGN_LAST = 4'hF;
    localparam logic [1:0] SKEW_LIMIT = 2'h3;

    typedef struct packed {
        logic [63:0] d;
        logic [7:0] c;
    } xlsd_xgmii_t;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] isk;
        logic [7:0] valid;
        logic [7:0] comma;
    } xlsd_mgt_rx_t;

    // one lane, two columns: column 0 in the low half
    typedef struct packed {
        logic [1:0] k;
        logic [1:0] ok;
        logic [15:0] d;
    } xlsd_lane_t;

    typedef enum logic [2:0] {
        SY_LOSS = 3'h1,
        SY_COMMA = 3'h2,
        SY_LOCK = 3'h4
    } xlsd_sync_t;

    typedef enum logic [2:0] {
        DS_WAIT = 3'h1,
        DS_ACQ = 3'h2,
        DS_ALIGNED = 3'h4
    } xlsd_dsk_t;

    localparam xlsd_xgmii_t IDLE_WORD = '{d: {8{K_IDLE}}, c: 8'hFF};
endpackage : xlsd_pkg

/* File: testbench/xlsd_core_sva.sv */
/* port-level assertions for xlsd_core.
   assumes a bind from the bench top and one clock domain. */
`timescale 1ns/100ps
module xlsd_core_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire xlsd_pkg::xlsd_mgt_rx_t mgt_rx_i,
    input wire xlsd_pkg::xlsd_xgmii_t xgmii_rx_o,
    input wire logic tx_ready_o,
    input wire logic [3:0] mgt_align_en_o,
    input wire logic [3:0] lane_sync_o,
    input wire logic align_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    function automatic bit raw_k(xlsd_pkg::xlsd_xgmii_t w);
        bit r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (w.c[i] && (w.d[8*i+:8] inside {8'hBC, 8'h7C, 8'h1C})) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : raw_k
    sequence unaligned_s; !align_o [*8]; endsequence
    // pipeline depth makes six clean cycles the safe window
    sequence clean_s; (&mgt_rx_i.valid) [*6]; endsequence
    reset_vals_a: assert property (disable iff (1'b0) rst_i |=>
        lane_sync_o == 4'h0 && !align_o && mgt_align_en_o == 4'hF
        && tx_ready_o) else $error("status wrong after reset");
    en_follow_a: assert property (mgt_align_en_o == ~lane_sync_o)
        else $error("align enable does not mirror lane lock");
    lock_delay_a: assert property ($fell(rst_i) |->
        (lane_sync_o == 4'h0) [*4]) else $error("lock came too soon");
    sync_hold_a: assert property (clean_s ##0 lane_sync_o == 4'hF
        |=> lane_sync_o == 4'hF) else $error("lock lost on clean input");
    dsk_gate_a: assert property ($rose(align_o) |->
        lane_sync_o == 4'hF && $past(lane_sync_o) == 4'hF)
        else $error("aligned without all lanes locked");
    align_loss_a: assert property (lane_sync_o != 4'hF |=> !align_o)
        else $error("aligned kept after lane loss");
    rx_err_a: assert property (unaligned_s |-> xgmii_rx_o ==
        {{8{xlsd_pkg::K_ERROR}}, 8'hFF}) else $error("unaligned rx not error");
    rx_kmap_a: assert property (!raw_k(xgmii_rx_o))
        else $error("raw sync code group reached client");
endmodule : xlsd_core_chk

/* File: testbench/xlsd_core_tb_top.sv */
/* bench top: drives the client side of xlsd_core, loops its lanes
   back through the transceiver model and judges what returns.
   assumes the design files, the model and the checker. */
`timescale 1ns/100ps
module xlsd_core_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    xlsd_pkg::xlsd_xgmii_t xgmii_tx_i = xlsd_pkg::IDLE_WORD;
    logic tx_valid_i = 1'b0;
    logic mgt_tx_ready_i = 1'b1;
    logic [3:0] skew = 4'h0;
    logic [3:0] bad = 4'h0;
    logic tx_ready_o, align_o;
    logic [3:0] mgt_align_en_o, lane_sync_o;
    xlsd_pkg::xlsd_xgmii_t mgt_tx_o, xgmii_rx_o;
    xlsd_pkg::xlsd_mgt_rx_t mgt_rx_i;
    // same core with both wrapper stages, fed the same stimulus
    xlsd_pkg::xlsd_xgmii_t p_mgt_tx_o, p_xgmii_rx_o;
    int miscompares = 0;
    int n_tests = 0;
    xlsd_core dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .xgmii_tx_i(xgmii_tx_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .mgt_tx_ready_i(mgt_tx_ready_i),
        .mgt_tx_o(mgt_tx_o), .mgt_rx_i(mgt_rx_i), .xgmii_rx_o(xgmii_rx_o),
        .mgt_align_en_o(mgt_align_en_o), .lane_sync_o(lane_sync_o),
        .align_o(align_o));
    xlsd_mgt_model mdl_u (.clk_i(clk_i), .skew_i(skew), .bad_i(bad),
        .mgt_tx_i(mgt_tx_o), .mgt_rx_o(mgt_rx_i));
    xlsd_core #(.EXTRA_TX_PIPE(1'b1), .EXTRA_RX_PIPE(1'b1)) dut_pipe_u (
        .clk_i(clk_i), .rst_i(rst_i),
        .xgmii_tx_i(xgmii_tx_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(), .mgt_tx_ready_i(mgt_tx_ready_i),
        .mgt_tx_o(p_mgt_tx_o), .mgt_rx_i(mgt_rx_i),
        .xgmii_rx_o(p_xgmii_rx_o), .mgt_align_en_o(), .lane_sync_o(),
        .align_o());
    initial begin
        forever begin
            #12.5 clk_i = ~clk_i;
        end
    end
    task automatic cmp(input string what, input logic [71:0] exp,
            input logic [71:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    function automatic xlsd_pkg::xlsd_xgmii_t lanes(xlsd_pkg::xlsd_xgmii_t w);
        xlsd_pkg::xlsd_xgmii_t m;
        for (int l = 0; l < 4; l++) begin
            m.d[16*l+:16] = {w.d[8*(l+4)+:8], w.d[8*l+:8]};
            m.c[2*l+:2] = {w.c[l+4], w.c[l]};
        end
        return m;
    endfunction : lanes
    function automatic xlsd_pkg::xlsd_xgmii_t wd(int k);
        return '{d: {56'h0, 8'(k)}, c: 8'h00};
    endfunction : wd
    task automatic wait_align();
        int i;
        for (i = 0; i < 300 && align_o !== 1'b1; i++) begin
            @(negedge clk_i);
        end
        cmp("align_o", 72'h1, 72'(align_o));
    endtask : wait_align
    task automatic t_idle();
        int na, nb;
        na = 0;
        nb = 0;
        repeat (16) begin
            @(negedge clk_i);
            na += (mgt_tx_o.d[7:0] === xlsd_pkg::K_ALIGN);
            nb += (mgt_tx_o.c !== 8'hFF);
            for (int b = 0; b < 8; b++) begin
                nb += !(mgt_tx_o.d[8*b+:8] inside {8'hBC, 8'h7C});
            end
        end
        cmp("align columns", 72'h1, 72'(na));
        cmp("idle bytes", 72'h0, 72'(nb));
    endtask : t_idle
    task automatic t_data(input int extra);
        xlsd_pkg::xlsd_xgmii_t w;
        w = '{d: 64'h8877665544332211, c: 8'h00};
        @(posedge clk_i);
        xgmii_tx_i <= w;
        tx_valid_i <= 1'b1;
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
        xgmii_tx_i <= xlsd_pkg::IDLE_WORD;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        cmp("mgt_tx_o", lanes(w), mgt_tx_o);
        @(negedge clk_i);
        cmp("piped mgt_tx_o", lanes(w), p_mgt_tx_o);
        repeat (2 + extra) @(negedge clk_i);
        cmp("rx upper", {w.d[31:0], 4'h0},
            {xgmii_rx_o.d[63:32], xgmii_rx_o.c[7:4]});
        @(negedge clk_i);
        cmp("rx lower", {w.d[63:32], 4'h0},
            {xgmii_rx_o.d[31:0], xgmii_rx_o.c[3:0]});
        cmp("piped rx upper", {w.d[31:0], 4'h0},
            {p_xgmii_rx_o.d[63:32], p_xgmii_rx_o.c[7:4]});
        @(negedge clk_i);
        cmp("piped rx lower", {w.d[63:32], 4'h0},
            {p_xgmii_rx_o.d[31:0], p_xgmii_rx_o.c[3:0]});
    endtask : t_data
    task automatic t_skew();
        @(posedge clk_i);
        skew <= 4'h8;
        repeat (40) @(posedge clk_i);
        wait_align();
        t_data(1);
        @(posedge clk_i);
        skew <= 4'h0;
        repeat (40) @(posedge clk_i);
        wait_align();
    endtask : t_skew
    task automatic t_bad();
        @(posedge clk_i);
        bad <= 4'h1;
        repeat (12) @(negedge clk_i);
        cmp("lock and align", 72'h1C, 72'({lane_sync_o, align_o}));
        cmp("rx unaligned", {{8{8'hFE}}, 8'hFF}, xgmii_rx_o);
        cmp("align enable", 72'h1, 72'(mgt_align_en_o));
        @(posedge clk_i);
        bad <= 4'h0;
        wait_align();
    endtask : t_bad
    task automatic t_fifo();
        int n, i;
        n = 0;
        @(posedge clk_i);
        mgt_tx_ready_i <= 1'b0;
        xgmii_tx_i <= wd(0);
        tx_valid_i <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_i);
            if (tx_ready_o !== 1'b1) break;
            n++;
            @(posedge clk_i);
            xgmii_tx_i <= wd(n);
        end
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
        mgt_tx_ready_i <= 1'b1;
        cmp("words taken", 72'(xlsd_pkg::FIFO_DEPTH), 72'(n));
        @(negedge clk_i);
        for (i = 0; i < 20 && mgt_tx_o.c !== 8'h00; i++) begin
            @(negedge clk_i);
        end
        for (i = 0; i < 32; i++) begin
            cmp("drained word", lanes(wd(i)), mgt_tx_o);
            @(negedge clk_i);
        end
    endtask : t_fifo
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        cmp("reset status", 72'h1,
            72'({lane_sync_o, align_o, tx_ready_o}));
        wait_align();
        t_idle();
        t_data(0);
        t_skew();
        t_bad();
        t_fifo();
        end_of_test();
    end
endmodule : xlsd_core_tb_top
bind xlsd_core xlsd_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .mgt_rx_i(mgt_rx_i), .xgmii_rx_o(xgmii_rx_o), .tx_ready_o(tx_ready_o),
    .mgt_align_en_o(mgt_align_en_o), .lane_sync_o(lane_sync_o),
    .align_o(align_o));

/* File: testbench/xlsd_mgt_model.sv */
/* transceiver loopback model: returns the transmit lanes as receive
   lanes, with optional one-cycle lane skew and bad code groups.
   assumes the core's clk_i and its lane-ordered word layout. */
`timescale 1ns/100ps
module xlsd_mgt_model (
    // clock
    input wire logic clk_i,
    // line faults
    input wire logic [3:0] skew_i,
    input wire logic [3:0] bad_i,
    // core side
    input wire xlsd_pkg::xlsd_xgmii_t mgt_tx_i,
    output xlsd_pkg::xlsd_mgt_rx_t mgt_rx_o
);
    xlsd_pkg::xlsd_xgmii_t last_r;
    always_ff @(posedge clk_i) begin
        last_r <= mgt_tx_i;
    end
    always_comb begin
        xlsd_pkg::xlsd_xgmii_t w;
        w = mgt_tx_i;
        for (int l = 0; l < 4; l++) begin
            if (skew_i[l]) begin
                w.d[16*l+:16] = last_r.d[16*l+:16];
                w.c[2*l+:2] = last_r.c[2*l+:2];
            end
        end
        for (int b = 0; b < 8; b++) begin
            // decode flags; a bad group returns junk, no comma
            mgt_rx_o.valid[b] = !bad_i[b/2];
            mgt_rx_o.isk[b] = w.c[b];
            mgt_rx_o.comma[b] = w.c[b] && !bad_i[b/2]
                && w.d[8*b+:8] == xlsd_pkg::K_COMMA;
            mgt_rx_o.data[8*b+:8] = bad_i[b/2] ? ~w.d[8*b+:8] : w.d[8*b+:8];
        end
    end
endmodule : xlsd_mgt_model
